// ### hw/pirqx_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  peripheral interrupt expander. Included by the package and the design.
*/
`ifndef PIRQX_REGS_SVH
`define PIRQX_REGS_SVH

// ==========================================================================
// Sizes
// ==========================================================================
`define PIRQX_NUM_REQ 96
`define PIRQX_GROUP_SIZE 8
`define PIRQX_NUM_GROUPS 12
`define PIRQX_NUM_EXT 3
`define PIRQX_PORTA_W 32
`define PIRQX_VEC_W 22
`define PIRQX_CNT_W 16

// ==========================================================================
// Word addresses on the register port
// ==========================================================================
`define PIRQX_ADDR_W 9
`define PIRQX_ENA_BASE 9'h000
`define PIRQX_FLAG_BASE 9'h010
`define PIRQX_EXT_CTL_BASE 9'h020
`define PIRQX_EXT_CNT_BASE 9'h024
`define PIRQX_IRQ_STAT 9'h030
`define PIRQX_IRQ_MASK 9'h031
`define PIRQX_VEC_BASE 9'h100

// ==========================================================================
// External channel control fields
// ==========================================================================
`define PIRQX_CTL_EN_BIT 0
`define PIRQX_CTL_POL_LSB 1
`define PIRQX_CTL_SEL_LSB 3
`define PIRQX_CTL_NMI_BIT 8
`define PIRQX_POL_FALL 2'h1
`define PIRQX_POL_RISE 2'h2
`define PIRQX_POL_BOTH 2'h3
`define PIRQX_CTL_RESET 9'h000

// Request slots that the first two external channels feed.
`define PIRQX_EXT1_REQ_IDX 3
`define PIRQX_EXT2_REQ_IDX 4

// ==========================================================================
// Interrupt status bits and CPU handshake
// ==========================================================================
`define PIRQX_STAT_W 4
`define PIRQX_STAT_SPURIOUS_BIT 3
`define PIRQX_ACK_NMI 4'h0
`define PIRQX_ACK_LINE13 4'hd
`define PIRQX_VEC_FETCH_CYCLES 8

`endif

// ### hw/pirqx_pkg.sv
/*
  Types shared by the peripheral interrupt expander.
  Assumes pirqx_regs.svh sits on the include path.
*/
`include "pirqx_regs.svh"

package pirqx_pkg;
  typedef logic [`PIRQX_CNT_W-1:0] pirqx_cnt_t;
  typedef logic [`PIRQX_VEC_W-1:0] pirqx_vec_t;
  typedef logic [`PIRQX_ADDR_W-1:0] pirqx_addr_t;
  typedef logic [8:0] pirqx_ctl_t;
endpackage

// ### hw/pirqx_expander.sv
/*
  Peripheral interrupt expander: ninety-six requests folded onto twelve CPU
  lines with per-request vectors and enables, plus three external edge
  channels with timestamp counters and a status/mask interrupt.
  Assumes one clock, inputs synchronous to it, and a CPU that acknowledges
  a line by a one-cycle pulse and waits for the vector.
*/
// Contract
// - Accept ninety-six peripheral interrupt requests.
// - Groups of eight drive twelve CPU lines.
// - Per-request vector in software-writable RAM.
// - CPU fetches vector; fetch takes eight cycles.
// - Per-request enable blocks forwarding.
// - Fixed order plus enables sets priority.
// - Three external channels, third non-maskable capable.
// - Third channel routes to line thirteen or NMI.
// - Falling, rising or both edge selection.
// - Each external channel has its own enable.
// - Sixteen-bit free-running counter per channel.
// - Valid edge clears that channel's counter.
// - Channel input selected from any port-A pin.
`timescale 1ns/1ps
`include "pirqx_regs.svh"

module pirqx_expander
  import pirqx_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [`PIRQX_NUM_REQ-1:0] i_req,
  input wire logic [`PIRQX_PORTA_W-1:0] i_port_a,
  input wire logic [`PIRQX_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_ack,
  input wire logic [3:0] i_ack_line,
  output logic o_vec_valid,
  output logic [`PIRQX_VEC_W-1:0] o_vec,
  output logic [`PIRQX_NUM_GROUPS-1:0] o_cpu_irq,
  output logic o_cpu_irq13,
  output logic o_cpu_nmi,
  output logic o_irq
);

  // ========================================================================
  // Helpers
  // ========================================================================
  // Returns {found, index} of the lowest set bit.
  function automatic logic [3:0] lowest_idx(input logic [7:0] bits);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (bits[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic edge_hit(input logic [1:0] pol, input logic prev, input logic cur);
    logic r;
    r = 1'b0;
    case (pol)
      `PIRQX_POL_FALL: r = prev & ~cur;
      `PIRQX_POL_RISE: r = ~prev & cur;
      `PIRQX_POL_BOTH: r = prev ^ cur;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ========================================================================
  // State
  // ========================================================================
  logic [`PIRQX_NUM_REQ-1:0] flag, next_flag, enable, next_enable;
  pirqx_ctl_t ext_ctl [`PIRQX_NUM_EXT];
  pirqx_ctl_t next_ext_ctl [`PIRQX_NUM_EXT];
  pirqx_cnt_t ext_cnt [`PIRQX_NUM_EXT];
  pirqx_cnt_t next_ext_cnt [`PIRQX_NUM_EXT];
  logic [`PIRQX_NUM_EXT-1:0] pin_prev, next_pin_prev, ext_evt;
  logic ch3_pend, next_ch3_pend;
  logic [`PIRQX_STAT_W-1:0] stat, next_stat, mask, next_mask;
  logic [3:0] busy, next_busy;
  logic next_vec_valid;
  logic [`PIRQX_VEC_W-1:0] next_vec;
  logic [31:0] next_rdata;
  logic [`PIRQX_NUM_REQ-1:0] pend, req_all, ack_clr;
  logic ack_take, spurious;
  pirqx_vec_t vram [`PIRQX_NUM_REQ];

  // Vectors are data, not control, so the RAM is left without a reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_wr && i_addr >= `PIRQX_VEC_BASE
        && i_addr < `PIRQX_VEC_BASE + 9'(`PIRQX_NUM_REQ)) begin
      vram[7'(i_addr - `PIRQX_VEC_BASE)] <= i_wdata[`PIRQX_VEC_W-1:0];
    end
  end

  // ========================================================================
  // External channels
  // ========================================================================
  always_comb begin
    for (int c = 0; c < `PIRQX_NUM_EXT; c++) begin
      next_pin_prev[c] = i_port_a[ext_ctl[c][`PIRQX_CTL_SEL_LSB +: 5]];
      // The edge is qualified by the enable before anything else sees it.
      ext_evt[c] = ext_ctl[c][`PIRQX_CTL_EN_BIT]
          && edge_hit(ext_ctl[c][`PIRQX_CTL_POL_LSB +: 2], pin_prev[c],
                      next_pin_prev[c]);
      next_ext_cnt[c] = ext_evt[c] ? '0 : pirqx_cnt_t'(ext_cnt[c] + 16'h0001);
    end
  end

  // ========================================================================
  // Request flags, acknowledge and vector fetch
  // ========================================================================
  always_comb begin
    logic [3:0] pick;
    logic [3:0] g;
    pick = 4'h0;
    g = 4'h0;
    req_all = i_req;
    req_all[`PIRQX_EXT1_REQ_IDX] = i_req[`PIRQX_EXT1_REQ_IDX] | ext_evt[0];
    req_all[`PIRQX_EXT2_REQ_IDX] = i_req[`PIRQX_EXT2_REQ_IDX] | ext_evt[1];
    pend = flag & enable;
    ack_clr = '0;
    spurious = 1'b0;
    next_vec = o_vec;
    next_vec_valid = 1'b0;
    next_ch3_pend = ch3_pend | ext_evt[2];
    ack_take = i_ack && busy == 4'h0;
    next_busy = (busy != 4'h0) ? busy - 4'h1 : busy;
    if (ack_take) begin
      next_busy = 4'(`PIRQX_VEC_FETCH_CYCLES - 1);
      next_vec_valid = 1'b1;
      next_vec = '0;
      if (i_ack_line >= 4'h1 && i_ack_line <= 4'(`PIRQX_NUM_GROUPS)) begin
        g = i_ack_line - 4'h1;
        pick = lowest_idx(pend[7'(g) * 8 +: 8]);
        if (pick[3]) begin
          next_vec = vram[7'(g) * 8 + 7'(pick[2:0])];
          ack_clr[7'(g) * 8 + 7'(pick[2:0])] = 1'b1;
        end else begin
          spurious = 1'b1;
        end
      end else if (i_ack_line == `PIRQX_ACK_NMI || i_ack_line == `PIRQX_ACK_LINE13) begin
        spurious = ~ch3_pend;
        next_ch3_pend = ext_evt[2];
      end else begin
        spurious = 1'b1;
      end
    end
    // A request arriving with its acknowledge stays pending.
    next_flag = (flag & ~ack_clr) | req_all;
  end

  always_comb begin
    for (int g = 0; g < `PIRQX_NUM_GROUPS; g++) begin
      o_cpu_irq[g] = |pend[g * 8 +: 8];
    end
    o_cpu_irq13 = ch3_pend && !ext_ctl[2][`PIRQX_CTL_NMI_BIT];
    o_cpu_nmi = ch3_pend && ext_ctl[2][`PIRQX_CTL_NMI_BIT];
    o_irq = |(stat & mask);
  end

  // ========================================================================
  // Register port
  // ========================================================================
  always_comb begin
    logic [8:0] off;
    off = 9'h000;
    next_enable = enable;
    next_mask = mask;
    next_rdata = 32'h0000_0000;
    for (int c = 0; c < `PIRQX_NUM_EXT; c++) begin
      next_ext_ctl[c] = ext_ctl[c];
    end
    next_stat = stat;
    if (i_wr && i_addr == `PIRQX_IRQ_STAT) begin
      next_stat = stat & ~i_wdata[`PIRQX_STAT_W-1:0];
    end
    next_stat = next_stat | {spurious, ext_evt};
    if (i_wr) begin
      off = i_addr - `PIRQX_ENA_BASE;
      if (i_addr < `PIRQX_ENA_BASE + 9'(`PIRQX_NUM_GROUPS)) begin
        next_enable[7'(off) * 8 +: 8] = i_wdata[7:0];
      end
      off = i_addr - `PIRQX_EXT_CTL_BASE;
      if (i_addr >= `PIRQX_EXT_CTL_BASE && off < 9'(`PIRQX_NUM_EXT)) begin
        next_ext_ctl[2'(off)] = i_wdata[8:0];
      end
      if (i_addr == `PIRQX_IRQ_MASK) begin
        next_mask = i_wdata[`PIRQX_STAT_W-1:0];
      end
    end
    if (i_rd) begin
      if (i_addr < `PIRQX_ENA_BASE + 9'(`PIRQX_NUM_GROUPS)) begin
        next_rdata[7:0] = enable[7'(i_addr) * 8 +: 8];
      end else if (i_addr >= `PIRQX_FLAG_BASE
                   && i_addr < `PIRQX_FLAG_BASE + 9'(`PIRQX_NUM_GROUPS)) begin
        off = i_addr - `PIRQX_FLAG_BASE;
        next_rdata[7:0] = flag[7'(off) * 8 +: 8];
      end else if (i_addr >= `PIRQX_EXT_CTL_BASE
                   && i_addr < `PIRQX_EXT_CTL_BASE + 9'(`PIRQX_NUM_EXT)) begin
        off = i_addr - `PIRQX_EXT_CTL_BASE;
        next_rdata[8:0] = ext_ctl[2'(off)];
      end else if (i_addr >= `PIRQX_EXT_CNT_BASE
                   && i_addr < `PIRQX_EXT_CNT_BASE + 9'(`PIRQX_NUM_EXT)) begin
        off = i_addr - `PIRQX_EXT_CNT_BASE;
        next_rdata[15:0] = ext_cnt[2'(off)];
      end else if (i_addr == `PIRQX_IRQ_STAT) begin
        next_rdata[`PIRQX_STAT_W-1:0] = stat;
      end else if (i_addr == `PIRQX_IRQ_MASK) begin
        next_rdata[`PIRQX_STAT_W-1:0] = mask;
      end else if (i_addr >= `PIRQX_VEC_BASE
                   && i_addr < `PIRQX_VEC_BASE + 9'(`PIRQX_NUM_REQ)) begin
        next_rdata[`PIRQX_VEC_W-1:0] = vram[7'(i_addr - `PIRQX_VEC_BASE)];
      end
    end
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag <= '0;
      enable <= '0;
      pin_prev <= '0;
      ch3_pend <= 1'b0;
      stat <= '0;
      mask <= '0;
      busy <= 4'h0;
      o_vec_valid <= 1'b0;
      o_vec <= '0;
      o_rdata <= 32'h0000_0000;
      for (int c = 0; c < `PIRQX_NUM_EXT; c++) begin
        ext_ctl[c] <= `PIRQX_CTL_RESET;
        ext_cnt[c] <= '0;
      end
    end else begin
      flag <= next_flag;
      enable <= next_enable;
      pin_prev <= next_pin_prev;
      ch3_pend <= next_ch3_pend;
      stat <= next_stat;
      mask <= next_mask;
      busy <= next_busy;
      o_vec_valid <= next_vec_valid;
      o_vec <= next_vec;
      o_rdata <= next_rdata;
      for (int c = 0; c < `PIRQX_NUM_EXT; c++) begin
        ext_ctl[c] <= next_ext_ctl[c];
        ext_cnt[c] <= next_ext_cnt[c];
      end
    end
  end

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  AST_DISABLED_GROUP_SILENT: assert property (enable[7:0] == 8'h00 |-> !o_cpu_irq[0])
    else $error("Disabled group drives its CPU line.");
  AST_REQ_LATCHED: assert property (i_req[5] |=> flag[5])
    else $error("Request not held pending.");
  AST_ACK_ANSWERED: assert property (i_ack && busy == 4'h0 |=> o_vec_valid)
    else $error("Vector not returned after acknowledge.");
  AST_FETCH_SPACING: assert property (o_vec_valid |=> !o_vec_valid [*7])
    else $error("Vector fetches closer than eight cycles.");
  AST_EDGE_CLEARS_CNT: assert property (ext_evt[0] |=> ext_cnt[0] == 16'h0000)
    else $error("Timestamp not cleared by valid edge.");
  // The first edge out of reset has no counting history, so the step check skips it.
  AST_CNT_FREE_RUN: assert property ($past(i_arst_n) && !ext_evt[1]
      |=> ext_cnt[1] == 16'($past(ext_cnt[1]) + 1))
    else $error("Timestamp counter did not advance.");
  AST_NMI_ROUTE: assert property (ch3_pend && ext_ctl[2][8] |-> o_cpu_nmi && !o_cpu_irq13)
    else $error("Third channel misrouted.");
  AST_EXT_ENABLE: assert property (!ext_ctl[0][0] && !stat[0] |=> !stat[0])
    else $error("Disabled channel raised an event.");
  AST_LOWEST_FIRST: assert property (i_ack && busy == 4'h0 && i_ack_line == 4'h1
      && pend[0] && pend[1] && !i_req[0] |=> !flag[0] && flag[1])
    else $error("Lowest pending request not served first.");
  AST_CH3_PENDS: assert property (ext_evt[2] |=> ch3_pend)
    else $error("Third channel edge not held pending.");
  AST_CH3_CNT_CLEAR: assert property (ext_evt[2] |=> ext_cnt[2] == 16'h0000)
    else $error("Third channel timestamp not cleared by valid edge.");
  AST_BUSY_REFUSES: assert property (busy != 4'h0 |=> !o_vec_valid)
    else $error("Vector answered during a fetch window.");
  AST_VEC_HOLDS: assert property (!o_vec_valid |-> o_vec == $past(o_vec))
    else $error("Vector changed without an answer.");
  AST_STAT_STICKY: assert property (stat[0]
      && !(i_wr && i_addr == `PIRQX_IRQ_STAT && i_wdata[0]) |=> stat[0])
    else $error("Edge status lost without a clear.");
  AST_LAST_GROUP_FORWARD: assert property (pend[95] |-> o_cpu_irq[11])
    else $error("Enabled pending request not forwarded to its line.");

endmodule

// ### test/pirqx_cpu_model.sv
/*
  Behavioural CPU core that takes the expander's lines and fetches vectors.
  Assumes the bench enables it only while acknowledges are wanted.
*/
`timescale 1ns/1ps

module pirqx_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic [11:0] i_irq,
  input wire logic i_irq13,
  input wire logic i_nmi,
  input wire logic i_vec_valid,
  input wire logic [21:0] i_vec,
  output logic o_ack,
  output logic [3:0] o_ack_line,
  output logic o_got,
  output logic [21:0] o_vec
);
  int wait_cnt;
  logic [3:0] ln;

  // ==========================================================================
  // Acknowledge and vector fetch
  // ==========================================================================
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      o_ack_line <= 4'h0;
      o_got <= 1'b0;
      o_vec <= 22'h0;
      wait_cnt = 0;
    end else begin
      o_ack <= 1'b0;
      o_got <= i_vec_valid;
      if (i_vec_valid) begin
        o_vec <= i_vec;
      end
      ln = 4'h0;
      for (int l = 12; l >= 1; l--) begin
        if (i_irq[l-1]) begin
          ln = 4'(l);
        end
      end
      if (wait_cnt > 0) begin
        wait_cnt--;
      end else if (i_en && (i_nmi || i_irq13 || (|i_irq))) begin
        o_ack <= 1'b1;
        o_ack_line <= i_nmi ? 4'h0 : (i_irq13 ? 4'hd : ln);
        // The core is busy fetching and saving context for this long.
        wait_cnt = 8;
      end
    end
  end
endmodule

// ### test/tb_peripheral_interrupt_expander.sv
/*
  Self-checking bench of the interrupt expander with a reference model.
  Assumes the design files and the CPU model are compiled first.
*/
`timescale 1ns/1ps
`include "pirqx_regs.svh"

module tb_peripheral_interrupt_expander
  import pirqx_pkg::*;
;
  logic clk, rst_n, wr, rd, ack, cpu_en, got, vv, irq13, nmi, irq;
  logic [95:0] req, r;
  logic [31:0] pa, wdata, rdata, d, c1, seed, ctl;
  pirqx_addr_t addr;
  logic [3:0] ack_line;
  logic [21:0] vec, gvec;
  logic [11:0] cirq, eirq;
  logic [1:0] pol;
  int bad_count, checks, p, ch;
  int vram[96];
  int exq[$];
  logic [7:0] ena[12];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  pirqx_expander dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_req(req), .i_port_a(pa),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ack(ack),
    .i_ack_line(ack_line), .o_vec_valid(vv), .o_vec(vec), .o_cpu_irq(cirq),
    .o_cpu_irq13(irq13), .o_cpu_nmi(nmi), .o_irq(irq));
  pirqx_cpu_model cpu (.i_clk_sys(clk), .i_arst_n(rst_n), .i_en(cpu_en), .i_irq(cirq),
    .i_irq13(irq13), .i_nmi(nmi), .i_vec_valid(vv), .i_vec(vec), .o_ack(ack),
    .o_ack_line(ack_line), .o_got(got), .o_vec(gvec));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task wrr(input pirqx_addr_t a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task rdr(input pirqx_addr_t a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task pin_to(input int n, input logic v);
    @(posedge clk);
    pa[n] <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task complete_run;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 32'd34896;
    {rst_n, wr, rd, cpu_en, req, wdata, addr} = '0;
    pa = rnd();
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdr(`PIRQX_ENA_BASE);
    chk(d, 32'h0);
    rdr(9'h0ff);
    chk(d, 32'h0);
    chk(32'(cirq), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 96; i++) begin
      vram[i] = int'(rnd() & 32'h3fffff);
      wrr(`PIRQX_VEC_BASE + 9'(i), 32'(vram[i]));
    end
    rdr(`PIRQX_VEC_BASE + 9'h05f);
    chk(d, 32'(vram[95]));
    for (int g = 0; g < 12; g++) begin
      // Requests 0 and 1 always pend together so the ordering check has work.
      ena[g] = 8'(rnd()) | ((g == 0) ? 8'h03 : 8'h00);
      wrr(`PIRQX_ENA_BASE + 9'(g), {24'h0, ena[g]});
    end
    r = {rnd(), rnd(), rnd()} | 96'h3;
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= '0;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 96; i++) begin
      if (r[i] && ena[i/8][i%8]) begin
        exq.push_back(vram[i]);
      end
    end
    for (int g = 0; g < 12; g++) begin
      eirq[g] = |(r[g*8+:8] & ena[g]);
    end
    chk(32'(cirq), 32'(eirq));
    cpu_en <= 1'b1;
    while (exq.size() > 0) begin
      for (int n = 0; n < 40 && got !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      chk(32'(gvec), 32'(exq.pop_front()));
      @(posedge clk);
      #1;
    end
    repeat (12) @(posedge clk);
    cpu_en <= 1'b0;
    #1;
    chk(32'(cirq), 32'h0);
    for (int g = 0; g < 12; g++) begin
      rdr(`PIRQX_FLAG_BASE + 9'(g));
      chk(d, {24'h0, r[g*8+:8] & ~ena[g]});
    end
    $display("vector test done");
    for (int t = 0; t < 6; t++) begin
      ch = t % 2;
      pol = 2'(t % 3 + 1);
      p = int'(rnd() & 32'h1f);
      ctl = 32'h1 | (32'(pol) << 1) | (32'(p) << 3);
      pin_to(p, 1'b0);
      wrr(`PIRQX_EXT_CTL_BASE + 9'(ch), ctl);
      wrr(`PIRQX_IRQ_STAT, 32'hf);
      pin_to(p, 1'b1);
      rdr(`PIRQX_IRQ_STAT);
      chk(32'(d[ch]), 32'(pol[1]));
      if (pol[1]) begin
        rdr(`PIRQX_EXT_CNT_BASE + 9'(ch));
        c1 = d;
        chk(32'(c1 < 32'h10), 32'h1);
        repeat (10) @(posedge clk);
        rdr(`PIRQX_EXT_CNT_BASE + 9'(ch));
        chk(d - c1, 32'd12);
      end
      wrr(`PIRQX_IRQ_STAT, 32'hf);
      pin_to(p, 1'b0);
      rdr(`PIRQX_IRQ_STAT);
      chk(32'(d[ch]), 32'(pol[0]));
      wrr(`PIRQX_EXT_CTL_BASE + 9'(ch), ctl & ~32'h1);
      wrr(`PIRQX_IRQ_STAT, 32'hf);
      pin_to(p, 1'b1);
      rdr(`PIRQX_IRQ_STAT);
      chk(32'(d[ch]), 32'h0);
      wrr(`PIRQX_EXT_CTL_BASE + 9'(ch), 32'h0);
    end
    $display("edge test done");
    for (int m = 0; m < 2; m++) begin
      p = int'(rnd() & 32'h1f);
      ctl = 32'h6 | (32'(p) << 3) | (32'(m) << 8);
      pin_to(p, 1'b0);
      // Configure while disabled so the new pin choice cannot fake an edge.
      wrr(`PIRQX_EXT_CTL_BASE + 9'h2, ctl);
      wrr(`PIRQX_IRQ_STAT, 32'h4);
      wrr(`PIRQX_EXT_CTL_BASE + 9'h2, ctl | 32'h1);
      pin_to(p, 1'b1);
      chk(32'(nmi), 32'(m));
      chk(32'(irq13), 32'(1 - m));
      rdr(`PIRQX_IRQ_STAT);
      chk(32'(d[2]), 32'h1);
      cpu_en <= 1'b1;
      repeat (20) @(posedge clk);
      cpu_en <= 1'b0;
      #1;
      chk(32'({nmi, irq13}), 32'h0);
    end
    $display("route test done");
    p = int'(rnd() & 32'h1f);
    wrr(`PIRQX_EXT_CTL_BASE, 32'h7 | (32'(p) << 3));
    wrr(`PIRQX_IRQ_MASK, 32'h0);
    wrr(`PIRQX_IRQ_STAT, 32'hf);
    pin_to(p, ~pa[p]);
    chk(32'(irq), 32'h0);
    wrr(`PIRQX_IRQ_MASK, 32'h1);
    rdr(`PIRQX_IRQ_MASK);
    chk(d, 32'h1);
    chk(32'(irq), 32'h1);
    wrr(`PIRQX_IRQ_STAT, 32'h1);
    @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    $display("interrupt test done");
    complete_run();
  end
endmodule
